//--- dpsem_regs.vh
// constants for the dual-port token flag host controller
`ifndef DPSEM_REGS_VH
`define DPSEM_REGS_VH
`define DPSEM_NUM_FLAGS 8
`define DPSEM_IDX_W 3
`define DPSEM_ADDR_W 17
`define DPSEM_DATA_W 36
`define DPSEM_D0_POS 0
`define DPSEM_FREE_VAL 1'b1
`define DPSEM_HELD_VAL 1'b0
`define DPSEM_ACC_NS 15
`define DPSEM_ACC_CYC ((`DPSEM_ACC_NS + 7) / 8)
`define DPSEM_GAP_CYC 8'h01
`endif

//--- dpsem_cycle.v
// one pin-level token space cycle: write or read, with select gap
`default_nettype none
`include "dpsem_regs.vh"
module dpsem_cycle #(
    parameter ADDR_W = `DPSEM_ADDR_W,
    parameter DATA_W = `DPSEM_DATA_W,
    parameter ACC_CYC = `DPSEM_ACC_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // request
    input wire start,
    input wire is_write,
    input wire [`DPSEM_IDX_W-1:0] idx,
    input wire wr_bit,
    output wire busy,
    output reg done_r,
    output reg rd_bit_r,
    // pins
    output reg token_space_select_n_r,
    output reg chip_enable_n_r,
    output reg rw_n_r,
    output reg output_enable_n_r,
    output reg byte_lane_enable_n_r,
    output reg [ADDR_W-1:0] addr_r,
    output reg [DATA_W-1:0] dq_out_r,
    output reg dq_oe_n_r,
    input wire [DATA_W-1:0] dq_in
);
    localparam S_IDLE = 3'b001;
    localparam S_ACT = 3'b010;
    localparam S_GAP = 3'b100;
    reg [2:0] st_r;
    reg [7:0] cnt_r;
    reg wr_r;
    assign busy = (st_r != S_IDLE);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= S_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            done_r <= 1'b0;
            rd_bit_r <= 1'b0;
            token_space_select_n_r <= 1'b1;
            chip_enable_n_r <= 1'b1;
            rw_n_r <= 1'b1;
            output_enable_n_r <= 1'b1;
            byte_lane_enable_n_r <= 1'b1;
            addr_r <= {ADDR_W{1'b0}};
            dq_out_r <= {DATA_W{1'b1}};
            dq_oe_n_r <= 1'b1;
        end else begin
            done_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (start) begin
                        st_r <= S_ACT;
                        cnt_r <= ACC_CYC[7:0];
                        wr_r <= is_write;
                        chip_enable_n_r <= 1'b1; // R23
                        token_space_select_n_r <= 1'b0; // R4
                        byte_lane_enable_n_r <= 1'b0;
                        rw_n_r <= ~is_write;
                        output_enable_n_r <= is_write;
                        addr_r <= {{(ADDR_W-`DPSEM_IDX_W){1'b0}}, idx}; // R5
                        dq_out_r <= {DATA_W{wr_bit}}; // R3
                        dq_oe_n_r <= ~is_write;
                    end
                end
                S_ACT: begin
                    if (cnt_r > 8'h01) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        // sample flag from bit 0 only, all bits carry it
                        if (!wr_r) begin
                            rd_bit_r <= dq_in[`DPSEM_D0_POS];
                        end
                        // drop select and enable so next read recaptures
                        token_space_select_n_r <= 1'b1; // R13
                        output_enable_n_r <= 1'b1; // R13
                        byte_lane_enable_n_r <= 1'b1;
                        rw_n_r <= 1'b1;
                        dq_oe_n_r <= 1'b1;
                        st_r <= S_GAP;
                        cnt_r <= `DPSEM_GAP_CYC;
                    end
                end
                S_GAP: begin
                    if (cnt_r > 8'h01) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        st_r <= S_IDLE;
                        done_r <= 1'b1;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end
endmodule // dpsem_cycle
`default_nettype wire

//--- dpsem_host.v
// host controller for one port of the dual-port token flags
// Summary of operation
// R1 - eight shared flags exist in the device, independent of memory
// R2 - flag zero means held, one means free
// R3 - request by writing zero, release by writing one from same side
// R4 - flags reached with token select low, chip enable inactive
// R5 - only the low three address bits pick the flag
// R6 - only data bit zero is taken on writes
// R7 - zero on free flag reads zero here, one on far side
// R8 - only the holder changes a held flag
// R9 - holder writing one frees flag unless far request pends
// R10 - non-holder zero waits in its request latch
// R11 - read returns flag on every data bit
// R12 - read value latched at select and output enable active
// R13 - select or output enable dropped between polling reads
// R14 - byte lane enable only gates outputs during reads
// R15 - acquire writes zero, reads back, zero is success
// R16 - after failure keep reading or write one to withdraw
// R17 - two request latches per flag, first zero owns it
// R18 - flags never stall memory accesses
// R19 - port in standby when neither enable selects it
// R20 - pending request takes flag when holder releases
// R21 - simultaneous requests granted to exactly one side
// R22 - every flag written one at initialisation
// R23 - chip enable held inactive during token accesses
// R24 - token access never touches memory array
`default_nettype none
`include "dpsem_regs.vh"
module dpsem_host #(
    parameter ADDR_W = `DPSEM_ADDR_W,
    parameter DATA_W = `DPSEM_DATA_W,
    parameter ACC_CYC = `DPSEM_ACC_CYC
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // user commands
    input wire cmd_acquire,
    input wire cmd_release,
    input wire cmd_retry,
    input wire [`DPSEM_IDX_W-1:0] cmd_idx,
    output wire cmd_ready,
    output reg result_valid_r,
    output reg result_got_r,
    output reg init_done_r,
    output reg [`DPSEM_NUM_FLAGS-1:0] held_r,
    // device pins
    output wire token_space_select_n,
    output wire chip_enable_n,
    output wire rw_n,
    output wire output_enable_n,
    output wire byte_lane_enable_n,
    output wire [ADDR_W-1:0] addr,
    output wire [DATA_W-1:0] dq_out,
    output wire dq_oe_n,
    input wire [DATA_W-1:0] dq_in
);
    localparam S_INIT = 5'b00001;
    localparam S_IDLE = 5'b00010;
    localparam S_WR = 5'b00100;
    localparam S_RD = 5'b01000;
    localparam S_WAIT = 5'b10000;
    reg [4:0] st_r;
    reg [4:0] st_nxt;
    reg [`DPSEM_IDX_W-1:0] idx_r;
    reg [`DPSEM_IDX_W-1:0] idx_nxt;
    reg val_r;
    reg val_nxt;
    reg then_read_r;
    reg then_read_nxt;
    reg go_r;
    reg go_nxt;
    reg wr_go_r;
    reg wr_go_nxt;
    reg result_valid_nxt;
    reg result_got_nxt;
    reg init_done_nxt;
    reg [`DPSEM_NUM_FLAGS-1:0] held_nxt;
    wire cyc_busy;
    wire cyc_done;
    wire cyc_bit;
    wire take_acq;
    wire take_rty;
    wire take_rel;
    wire last_idx;
    assign cmd_ready = (st_r == S_IDLE);
    // one command at a time, acquire before retry before release
    assign take_acq = cmd_ready && cmd_acquire;
    assign take_rty = cmd_ready && !cmd_acquire && cmd_retry;
    assign take_rel = cmd_ready && !cmd_acquire && !cmd_retry && cmd_release;
    // eight flags fill the index, so all ones marks the last one
    assign last_idx = &idx_r;
    dpsem_cycle #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .ACC_CYC(ACC_CYC)) u_cyc (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(go_r),
        .is_write(wr_go_r),
        .idx(idx_r),
        .wr_bit(val_r),
        .busy(cyc_busy),
        .done_r(cyc_done),
        .rd_bit_r(cyc_bit),
        .token_space_select_n_r(token_space_select_n),
        .chip_enable_n_r(chip_enable_n),
        .rw_n_r(rw_n),
        .output_enable_n_r(output_enable_n),
        .byte_lane_enable_n_r(byte_lane_enable_n),
        .addr_r(addr),
        .dq_out_r(dq_out),
        .dq_oe_n_r(dq_oe_n),
        .dq_in(dq_in)
    );
    always @* begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        val_nxt = val_r;
        then_read_nxt = then_read_r;
        go_nxt = 1'b0;
        wr_go_nxt = wr_go_r;
        result_valid_nxt = 1'b0;
        result_got_nxt = result_got_r;
        init_done_nxt = init_done_r;
        held_nxt = held_r;
        case (st_r)
            S_INIT: begin
                // flags power up unknown, so free each from this side
                if (!cyc_busy && !go_r) begin
                    go_nxt = 1'b1;
                    wr_go_nxt = 1'b1;
                    val_nxt = `DPSEM_FREE_VAL; // R22
                    then_read_nxt = 1'b0;
                    st_nxt = S_WAIT;
                end
            end
            S_IDLE: begin
                if (take_acq) begin
                    idx_nxt = cmd_idx;
                    val_nxt = `DPSEM_HELD_VAL; // R15
                    wr_go_nxt = 1'b1;
                    go_nxt = 1'b1;
                    then_read_nxt = 1'b1;
                    st_nxt = S_WR;
                end else if (take_rty) begin
                    // poll only, the request latch already holds our zero
                    idx_nxt = cmd_idx;
                    wr_go_nxt = 1'b0;
                    go_nxt = 1'b1; // R16
                    st_nxt = S_RD;
                end else if (take_rel) begin
                    // also withdraws a request left pending by a failed acquire
                    idx_nxt = cmd_idx;
                    val_nxt = `DPSEM_FREE_VAL; // R3
                    wr_go_nxt = 1'b1;
                    go_nxt = 1'b1;
                    then_read_nxt = 1'b0;
                    held_nxt[cmd_idx] = 1'b0;
                    st_nxt = S_WR;
                end
            end
            S_WR: begin
                if (cyc_done) begin
                    if (then_read_r) begin
                        // read back next, nothing else may slip in between
                        wr_go_nxt = 1'b0;
                        go_nxt = 1'b1; // R15
                        st_nxt = S_RD;
                    end else begin
                        result_valid_nxt = 1'b1;
                        result_got_nxt = 1'b0;
                        st_nxt = S_IDLE;
                    end
                end
            end
            S_RD: begin
                if (cyc_done) begin
                    // a one read back means the far side holds it, our zero waits
                    result_valid_nxt = 1'b1;
                    result_got_nxt = (cyc_bit == `DPSEM_HELD_VAL); // R15
                    held_nxt[idx_r] = (cyc_bit == `DPSEM_HELD_VAL);
                    st_nxt = S_IDLE;
                end
            end
            S_WAIT: begin
                if (cyc_done) begin
                    if (last_idx) begin
                        init_done_nxt = 1'b1;
                        st_nxt = S_IDLE;
                    end else begin
                        idx_nxt = idx_r + 3'h1;
                        st_nxt = S_INIT;
                    end
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end
    // only this block holds state; reset restarts the freeing pass at flag 0
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= S_INIT;
            idx_r <= {`DPSEM_IDX_W{1'b0}};
            val_r <= `DPSEM_FREE_VAL;
            then_read_r <= 1'b0;
            go_r <= 1'b0;
            wr_go_r <= 1'b0;
            result_valid_r <= 1'b0;
            result_got_r <= 1'b0;
            init_done_r <= 1'b0;
            held_r <= {`DPSEM_NUM_FLAGS{1'b0}};
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            val_r <= val_nxt;
            then_read_r <= then_read_nxt;
            go_r <= go_nxt;
            wr_go_r <= wr_go_nxt;
            result_valid_r <= result_valid_nxt;
            result_got_r <= result_got_nxt;
            init_done_r <= init_done_nxt;
            held_r <= held_nxt;
        end
    end
endmodule // dpsem_host
`default_nettype wire

//--- dpsem_host_properties.sv
// pin-level assertions for the token flag host controller
`default_nettype none
module dpsem_host_checker #(
    parameter ADDR_W = 17,
    parameter DATA_W = 36,
    parameter ACC_CYC = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // status
    input wire logic cmd_ready,
    input wire logic init_done_r,
    // device pins
    input wire logic token_space_select_n,
    input wire logic chip_enable_n,
    input wire logic rw_n,
    input wire logic output_enable_n,
    input wire logic byte_lane_enable_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    property p_mem_off; chip_enable_n; endproperty
    a_mem_off: assert property (p_mem_off) else $error("memory enable active");
    property p_sel; !token_space_select_n |-> !byte_lane_enable_n && addr[ADDR_W-1:3] == '0;
    endproperty
    a_sel: assert property (p_sel) else $error("token access pins wrong");
    property p_wr; !rw_n |-> !token_space_select_n && !dq_oe_n; endproperty
    a_wr: assert property (p_wr) else $error("write outside token access");
    property p_rd; !output_enable_n |-> rw_n && dq_oe_n && !token_space_select_n; endproperty
    a_rd: assert property (p_rd) else $error("read with bus driven");
    property p_gap; $fell(token_space_select_n) |-> ##[1:4] $rose(token_space_select_n);
    endproperty
    a_gap: assert property (p_gap) else $error("select never dropped");
    property p_test; !rw_n && !dq_out[0] |-> ##[1:12] !output_enable_n; endproperty
    a_test: assert property (p_test) else $error("no read back after request");
    property p_init; !init_done_r && !rw_n |-> dq_out[0]; endproperty
    a_init: assert property (p_init) else $error("init wrote zero");
    property p_rdy; !init_done_r |-> !cmd_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready before init");
endmodule // dpsem_host_checker
bind dpsem_host dpsem_host_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .ACC_CYC(ACC_CYC)) i_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmd_ready(cmd_ready), .init_done_r(init_done_r),
    .token_space_select_n(token_space_select_n), .chip_enable_n(chip_enable_n), .rw_n(rw_n),
    .output_enable_n(output_enable_n), .byte_lane_enable_n(byte_lane_enable_n),
    .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n));
`default_nettype wire

//--- dpsem_dev_model.sv
// behavioural token flag device for the host bench
`default_nettype none
module dpsem_dev_model (
    // host side pins
    input wire logic sel_n,
    input wire logic ce_n,
    input wire logic rw_n,
    input wire logic oe_n,
    input wire logic be_n,
    input wire logic [2:0] token_index_bits,
    input wire logic [35:0] dq_out,
    output logic [35:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // power-up state is junk and never cleared
    logic [7:0] req_l = 8'h00, req_r = 8'h00;
    logic [7:0] own_l = 8'h0F, own_r = 8'hF0;
    logic w_v, rd_q = 1'b1, rd_on = 1'b0;
    logic [2:0] w_i;
    wire logic wr_act = !sel_n && !rw_n && ce_n;
    wire logic rd_act = !sel_n && !oe_n && !be_n && ce_n;
    task automatic put(input logic far, input logic [2:0] i, input logic v);
        req_r[i] = far ? v : req_r[i];
        req_l[i] = far ? req_l[i] : v;
        if (!v && !own_l[i] && !own_r[i]) begin
            own_r[i] = far;
            own_l[i] = !far;
        end else if (v && (far ? own_r[i] : own_l[i])) begin
            own_r[i] = !far && !req_r[i];
            own_l[i] = far && !req_l[i];
        end
    endtask
    always @(posedge wr_act) begin
        #1;
        w_i = token_index_bits;
        w_v = dq_out[0];
    end
    always @(negedge wr_act) put(1'b0, w_i, w_v);
    always @(posedge rd_act) begin
        #1;
        rd_q = !own_l[token_index_bits];
        rd_on = 1'b1;
    end
    always @(negedge rd_act) rd_on = 1'b0;
    // released bus shows the inverse, so a stale sample cannot pass
    assign dq_in = rd_on ? {36{rd_q}} : {36{!rd_q}};
endmodule // dpsem_dev_model
`default_nettype wire

//--- test_dual_port_semaphore_latches.sv
// self-checking bench for the token flag host controller
`default_nettype none
module test_dual_port_semaphore_latches;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b1;
    logic cmd_acquire = 1'b0, cmd_release = 1'b0, cmd_retry = 1'b0;
    logic [2:0] cmd_idx = 3'h0;
    wire logic cmd_ready, result_valid_r, result_got_r, init_done_r;
    wire logic sel_n, ce_n, rw_n, oe_n, be_n, dq_oe_n;
    wire logic [7:0] held_r;
    wire logic [16:0] addr;
    wire logic [35:0] dq_out, dq_in;
    int err_total = 0;
    int n_checks = 0;
    // kind idx far {got,far view} held; kind 0 take 1 free 2 poll; far 1 zero 2 one
    logic [16:0] rows [12] = '{
        {2'h0, 3'h0, 2'h0, 2'h3, 8'h01}, {2'h1, 3'h0, 2'h1, 2'h0, 8'h00},
        {2'h0, 3'h0, 2'h0, 2'h0, 8'h00}, {2'h2, 3'h0, 2'h0, 2'h0, 8'h00},
        {2'h2, 3'h0, 2'h2, 2'h3, 8'h01}, {2'h1, 3'h0, 2'h0, 2'h1, 8'h00},
        {2'h0, 3'h5, 2'h1, 2'h0, 8'h00}, {2'h1, 3'h5, 2'h0, 2'h0, 8'h00},
        {2'h0, 3'h5, 2'h2, 2'h3, 8'h20}, {2'h0, 3'h7, 2'h0, 2'h3, 8'hA0},
        {2'h1, 3'h5, 2'h0, 2'h1, 8'h80}, {2'h1, 3'h7, 2'h0, 2'h1, 8'h00}};
    dpsem_host i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_acquire(cmd_acquire),
        .cmd_release(cmd_release), .cmd_retry(cmd_retry), .cmd_idx(cmd_idx),
        .cmd_ready(cmd_ready), .result_valid_r(result_valid_r), .result_got_r(result_got_r),
        .init_done_r(init_done_r), .held_r(held_r), .token_space_select_n(sel_n),
        .chip_enable_n(ce_n), .rw_n(rw_n), .output_enable_n(oe_n), .byte_lane_enable_n(be_n),
        .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    dpsem_dev_model i_dev (.sel_n(sel_n), .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .be_n(be_n),
        .token_index_bits(addr[2:0]), .dq_out(dq_out), .dq_in(dq_in));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic do_cmd(input logic [1:0] kind, input logic [2:0] idx);
        for (int n = 0; n < 100 && cmd_ready !== 1'b1; n++) begin
            @(negedge sys_clk);
        end
        cmd_idx = idx;
        cmd_acquire = (kind == 2'h0);
        cmd_release = (kind == 2'h1);
        cmd_retry = (kind == 2'h2);
        @(negedge sys_clk);
        {cmd_acquire, cmd_release, cmd_retry} = 3'h0;
        for (int n = 0; n < 100 && result_valid_r !== 1'b1; n++) begin
            @(negedge sys_clk);
        end
        chk("done", 8'h01, {7'h0, result_valid_r});
    endtask
    // both sides must have freed every flag before use
    task automatic wait_init();
        for (int n = 0; n < 400 && init_done_r !== 1'b1; n++) begin
            @(negedge sys_clk);
        end
        chk("free", 8'h00, i_dev.own_l | i_dev.own_r | {7'h0, ~init_done_r});
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        results();
    end
    initial begin
        rst_b = 1'b0;
        for (int k = 0; k < 8; k++) begin
            i_dev.put(1'b1, k[2:0], 1'b1);
        end
        repeat (4) @(negedge sys_clk);
        chk("idle", 8'h07, {5'h0, sel_n, ce_n, dq_oe_n});
        rst_b = 1'b1;
        wait_init();
        foreach (rows[k]) begin
            if (rows[k][11:10] != 2'h0) begin
                i_dev.put(1'b1, rows[k][14:12], rows[k][11]);
            end
            do_cmd(rows[k][16:15], rows[k][14:12]);
            chk("got", 8'(rows[k][9:8]), {6'h0, result_got_r, ~i_dev.own_r[rows[k][14:12]]});
            chk("held", rows[k][7:0], held_r);
        end
        // reset while a flag is held: re-init must free it
        do_cmd(2'h0, 3'h3);
        rst_b = 1'b0;
        @(negedge sys_clk);
        chk("idle", 8'h07, {5'h0, sel_n, ce_n, dq_oe_n});
        rst_b = 1'b1;
        wait_init();
        results();
    end
endmodule // test_dual_port_semaphore_latches
`default_nettype wire
